// *** rtl/stipple_span_writer.sv ***
// stipple span engine: one host frame buffer write draws 32 pixels
// assumes memory port on the same clock, one request held until mem_ack
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - in opaque mode a host frame buffer write draws a two-colour masked 32-pixel span from that address.
// - the host frame buffer write starts the span and its data word is the stipple mask.
// - the stipple word is expanded to one bit per pixel over all 32 pixels.
// - in opaque mode only pixels with a pixel mask bit of one are written, others keep their value.
// - in opaque mode enabled pixels take foreground for stipple one and background for stipple zero.
// - raster op and plane mask apply to every pixel write of a span.
// - destination kind comes from raster op bits 9:8 and byte select from 11:10, all kinds supported.
// - source bitmap settings are ignored and no source is read from memory.
// - memory is written 64 bits per access, eight packed or two wide pixels.
// - accesses covered only by leading or trailing zero mask bits are skipped.
// - in transparent mode a host write draws a single-colour masked 32-pixel span.
// - in transparent mode no pixel mask is used and stipple zero suppresses the write.
// - transparent mode otherwise behaves as opaque mode.
module stipple_span_writer
  import span_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              fb_wr,
  input  wire logic [AW-1:0]     fb_addr,
  input  wire logic [31:0]       fb_data,
  output logic                   fb_busy,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [AW-4:0]     mem_addr,
  output logic      [63:0]       mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [63:0]       mem_rdata
);

  logic [31:0]   pixel_write_mask_reg_r;
  logic [31:0]   bit_plane_mask_reg_r;
  logic [31:0]   raster_operation_reg_r;
  logic [31:0]   foreground_colour_reg_r;
  logic [31:0]   background_colour_reg_r;
  logic [31:0]   mode_reg_r;
  logic          overrun_r;
  logic [31:0]   rdata_r;
  span_state_t   state_r;
  logic          busy_r;
  logic          req_r;
  logic          we_r;
  logic [AW-4:0] addr_r;
  logic [63:0]   wdata_r;
  logic [63:0]   dest_r;
  logic [31:0]   stip_r;
  logic [31:0]   en_r;
  logic [2:0]    off_r;
  logic [1:0]    fmt_r;
  logic [4:0]    beat_r;
  logic [4:0]    beat_last_r;
  logic [AW-4:0] base_r;

  logic          accept;
  logic          transp;
  logic          packed_new;
  logic [31:0]   en_new;
  logic [4:0]    first_px;
  logic [4:0]    last_px;
  logic [5:0]    pos_first;
  logic [5:0]    pos_last;
  logic [4:0]    beat_first;
  logic [4:0]    beat_last;
  logic [7:0]    slot_en;
  logic [7:0]    slot_fg;
  logic [63:0]   merged;

  assign accept     = fb_wr && !busy_r;
  assign transp     = mode_reg_r[MODE_TRANSP];
  assign packed_new = raster_operation_reg_r[DST_BM_LSB +: 2] == DST_PACKED8;
  // transparent mode drops the pixel mask and writes where stipple is set
  assign en_new = transp ? fb_data : pixel_write_mask_reg_r;

  // first and last enabled pixel bound the beats that are issued
  always_comb begin
    first_px = '0;
    last_px  = '0;
    for (int i = SPAN_PX - 1; i >= 0; i--) begin
      if (en_new[i]) first_px = 5'(i);
    end
    for (int i = 0; i < SPAN_PX; i++) begin
      if (en_new[i]) last_px = 5'(i);
    end
  end

  // packed spans may start halfway into a quadword
  always_comb begin
    logic [2:0] off;
    off = (packed_new && fb_addr[2]) ? 3'h4 : 3'h0;
    pos_first  = {1'b0, first_px} + {3'b000, off};
    pos_last   = {1'b0, last_px} + {3'b000, off};
    beat_first = packed_new ? {2'b00, pos_first[5:3]} : pos_first[5:1];
    beat_last  = packed_new ? {2'b00, pos_last[5:3]} : pos_last[5:1];
  end

  // map beat slots back to span pixels, bit n is pixel n from start
  always_comb begin
    int p;
    int ppb;
    p       = 0;
    ppb     = (fmt_r == DST_PACKED8) ? PX_PACK : PX_WIDE;
    slot_en = '0;
    slot_fg = '0;
    for (int s = 0; s < PX_PACK; s++) begin
      p = int'(beat_r) * ppb + s - int'(off_r);
      if (s < ppb && p >= 0 && p < SPAN_PX) begin
        slot_en[s] = en_r[p];
        slot_fg[s] = stip_r[p];
      end
    end
  end

  beat_merge u_merge (
    .dst_fmt    (fmt_r),
    .dst_byte   (raster_operation_reg_r[DST_BYTE_LSB +: 2]),
    .rop        (raster_operation_reg_r[ROP_LSB +: 4]),
    .plane_mask (bit_plane_mask_reg_r),
    .fg         (foreground_colour_reg_r),
    .bg         (background_colour_reg_r),
    .slot_en    (slot_en),
    .slot_fg    (slot_fg),
    .dest       (dest_r),
    .merged     (merged)
  );

  // software writable registers; source settings have no field here
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pixel_write_mask_reg_r  <= PIXEL_MASK_RST;
      bit_plane_mask_reg_r    <= PLANE_MASK_RST;
      raster_operation_reg_r  <= ROP_RST;
      foreground_colour_reg_r <= COLOUR_RST;
      background_colour_reg_r <= COLOUR_RST;
      mode_reg_r              <= MODE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        PIXEL_MASK_OFS: pixel_write_mask_reg_r  <= reg_wdata;
        PLANE_MASK_OFS: bit_plane_mask_reg_r    <= reg_wdata;
        ROP_OFS:        raster_operation_reg_r  <= reg_wdata & 32'h0000_0f0f;
        FG_OFS:         foreground_colour_reg_r <= reg_wdata;
        BG_OFS:         background_colour_reg_r <= reg_wdata;
        MODE_OFS:       mode_reg_r <= {31'h0, reg_wdata[MODE_TRANSP]};
        default: ;
      endcase
    end
  end

  // host write while busy is dropped; set beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overrun_r <= 1'b0;
    end else if (fb_wr && busy_r) begin
      overrun_r <= 1'b1;
    end else if (reg_wr && reg_addr == STATUS_OFS &&
                 reg_wdata[STAT_OVERRUN]) begin
      overrun_r <= 1'b0;
    end
  end

  // read data one cycle after the strobe, unmapped reads as zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        PIXEL_MASK_OFS: rdata_r <= pixel_write_mask_reg_r;
        PLANE_MASK_OFS: rdata_r <= bit_plane_mask_reg_r;
        ROP_OFS:        rdata_r <= raster_operation_reg_r;
        FG_OFS:         rdata_r <= foreground_colour_reg_r;
        BG_OFS:         rdata_r <= background_colour_reg_r;
        MODE_OFS:       rdata_r <= mode_reg_r;
        STATUS_OFS:     rdata_r <= {30'h0, overrun_r, busy_r};
        default:        rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // span capture at the host write; an empty mask issues no access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stip_r      <= '0;
      en_r        <= '0;
      off_r       <= '0;
      fmt_r       <= '0;
      beat_last_r <= '0;
      base_r      <= '0;
    end else if (accept) begin
      stip_r      <= fb_data;
      en_r        <= en_new;
      off_r       <= (packed_new && fb_addr[2]) ? 3'h4 : 3'h0;
      fmt_r       <= raster_operation_reg_r[DST_BM_LSB +: 2];
      beat_last_r <= beat_last;
      base_r      <= fb_addr[AW-1:3];
    end
  end

  // read-modify-write per beat; only destination is ever read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      dest_r  <= '0;
      beat_r  <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept && en_new != 32'h0000_0000) begin
            state_r <= ST_READ;
            busy_r  <= 1'b1;
            req_r   <= 1'b1;
            we_r    <= 1'b0;
            beat_r  <= beat_first;
            addr_r  <= fb_addr[AW-1:3] + (AW-3)'(beat_first);
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            req_r   <= 1'b0;
            dest_r  <= mem_rdata;
            state_r <= ST_MERGE;
          end
        end
        ST_MERGE: begin
          wdata_r <= merged;
          req_r   <= 1'b1;
          we_r    <= 1'b1;
          state_r <= ST_WRITE;
        end
        ST_WRITE: begin
          if (mem_ack) begin
            we_r <= 1'b0;
            if (beat_r == beat_last_r) begin
              req_r   <= 1'b0;
              busy_r  <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              // next beat read goes out straight behind the write
              beat_r  <= beat_r + 5'h01;
              addr_r  <= base_r + (AW-3)'(beat_r + 5'h01);
              state_r <= ST_READ;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign reg_rdata = rdata_r;
  assign fb_busy   = busy_r;
  assign mem_req   = req_r;
  assign mem_we    = we_r;
  assign mem_addr  = addr_r;
  assign mem_wdata = wdata_r;

  // checks on the span engine
  property p_start;
    @(posedge core_clk) disable iff (!rst_n)
      (accept && en_new != 32'h0000_0000)
      |=> (fb_busy && mem_req && !mem_we);
  endproperty
  a_start: assert property (p_start)
    else $error("span did not start a read");

  property p_empty;
    @(posedge core_clk) disable iff (!rst_n)
      (accept && en_new == 32'h0000_0000) |=> (!fb_busy && !mem_req)[*2];
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty mask issued an access");

  property p_transp_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (accept && transp && fb_data == 32'h0000_0000) |=> !mem_req;
  endproperty
  a_transp_zero: assert property (p_transp_zero)
    else $error("clear stipple wrote in transparent mode");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)
                                 && $stable(mem_we));
  endproperty
  a_hold: assert property (p_hold)
    else $error("memory request dropped before ack");

  property p_span_range;
    @(posedge core_clk) disable iff (!rst_n)
      mem_req |-> (mem_addr - base_r) < (AW-3)'(16);
  endproperty
  a_span_range: assert property (p_span_range)
    else $error("access outside the 32-pixel span");

  property p_rmw_order;
    @(posedge core_clk) disable iff (!rst_n)
      (mem_req && !mem_we && mem_ack) |=> !mem_req ##1 (mem_req && mem_we);
  endproperty
  a_rmw_order: assert property (p_rmw_order)
    else $error("write did not follow its read");

  property p_plane_keep;
    @(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_MERGE && bit_plane_mask_reg_r == 32'h0000_0000)
      |=> (mem_wdata == dest_r);
  endproperty
  a_plane_keep: assert property (p_plane_keep)
    else $error("plane mask zero altered memory");

  property p_pixmask_keep;
    @(posedge core_clk) disable iff (!rst_n)
      (state_r == ST_MERGE && slot_en == 8'h00) |=> (mem_wdata == dest_r);
  endproperty
  a_pixmask_keep: assert property (p_pixmask_keep)
    else $error("disabled pixels were modified");

  property p_rd_latency;
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == FG_OFS && !reg_wr)
      |=> (reg_rdata == $past(foreground_colour_reg_r));
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("foreground read back wrong");

  property p_busy_drop;
    @(posedge core_clk) disable iff (!rst_n)
      (fb_wr && fb_busy) |=> $stable(stip_r);
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("write during busy changed the span");

  c_opaque: cover property (@(posedge core_clk) disable iff (!rst_n)
    accept && !transp && en_new != 32'h0000_0000);
  c_transp: cover property (@(posedge core_clk) disable iff (!rst_n)
    accept && transp && fb_data != 32'h0000_0000);
  c_multi: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_WRITE && mem_ack && beat_r != beat_last_r);
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_n)
    fb_wr && fb_busy);

endmodule : stipple_span_writer

// *** rtl/span_pkg.sv ***
// constants, field layouts and types shared by the stipple span writer
// assumes one clock domain; offsets are byte addresses on the register port
package span_pkg;

  localparam int ADDR_W   = 24;         // frame buffer byte address width
  localparam int REG_AW   = 5;          // register port address width
  localparam int SPAN_PX  = 32;         // pixels per span
  localparam int PX_PACK  = 8;          // pixels per beat, packed 8-bpp
  localparam int PX_WIDE  = 2;          // pixels per beat, other formats

  // register byte offsets
  localparam logic [4:0] PIXEL_MASK_OFS = 5'h00;
  localparam logic [4:0] PLANE_MASK_OFS = 5'h04;
  localparam logic [4:0] ROP_OFS        = 5'h08;
  localparam logic [4:0] FG_OFS         = 5'h0c;
  localparam logic [4:0] BG_OFS         = 5'h10;
  localparam logic [4:0] MODE_OFS       = 5'h14;
  localparam logic [4:0] STATUS_OFS     = 5'h18;

  // field positions
  localparam int ROP_LSB       = 0;
  localparam int DST_BM_LSB    = 8;
  localparam int DST_BYTE_LSB  = 10;
  localparam int MODE_TRANSP   = 0;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_OVERRUN  = 1;

  // reset values
  localparam logic [31:0] PIXEL_MASK_RST = 32'hffff_ffff;
  localparam logic [31:0] PLANE_MASK_RST = 32'hffff_ffff;
  localparam logic [31:0] ROP_RST        = 32'h0000_000c; // copy source
  localparam logic [31:0] COLOUR_RST     = 32'h0000_0000;
  localparam logic [31:0] MODE_RST       = 32'h0000_0000;

  // destination bitmap kinds, raster op register bits 9:8
  typedef enum logic [1:0] {
    DST_PACKED8   = 2'b00,
    DST_UNPACKED8 = 2'b01,
    DST_12BPP     = 2'b10,
    DST_24BPP     = 2'b11
  } dst_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_MERGE = 2'b10,
    ST_WRITE = 2'b11
  } span_state_t;

endpackage : span_pkg

// *** rtl/beat_merge.sv ***
// combines one 64-bit destination beat with the span colours
// assumes slot flags are already resolved to pixel positions in the beat
`timescale 1ns/1ps
module beat_merge
  import span_pkg::*;
(
  input  wire logic [1:0]  dst_fmt,
  input  wire logic [1:0]  dst_byte,
  input  wire logic [3:0]  rop,
  input  wire logic [31:0] plane_mask,
  input  wire logic [31:0] fg,
  input  wire logic [31:0] bg,
  input  wire logic [7:0]  slot_en,
  input  wire logic [7:0]  slot_fg,
  input  wire logic [63:0] dest,
  output logic      [63:0] merged
);

  // per 32-bit word: build source and write mask, then rop and plane mask
  always_comb begin
    logic [31:0] src;
    logic [31:0] wmask;
    logic [31:0] d;
    logic [31:0] col;
    src    = '0;
    wmask  = '0;
    d      = '0;
    col    = '0;
    merged = dest;
    for (int w = 0; w < 2; w++) begin
      d     = dest[32*w +: 32];
      src   = '0;
      wmask = '0;
      case (dst_fmt)
        DST_PACKED8: begin
          // byte lane picks the matching colour byte
          for (int b = 0; b < 4; b++) begin
            col = slot_fg[4*w+b] ? fg : bg;
            src[8*b +: 8] = col[8*b +: 8];
            wmask[8*b +: 8] = {8{slot_en[4*w+b]}};
          end
        end
        DST_UNPACKED8: begin
          col   = slot_fg[w] ? fg : bg;
          src   = {4{col[7:0]}};
          wmask = {24'h00_0000, {8{slot_en[w]}}} << {dst_byte, 3'b000};
        end
        DST_12BPP: begin
          src   = slot_fg[w] ? fg : bg;
          wmask = dst_byte[0] ? {8'h00, {12{slot_en[w]}}, 12'h000}
                              : {20'h0_0000, {12{slot_en[w]}}};
        end
        default: begin
          src   = slot_fg[w] ? fg : bg;
          wmask = {8'h00, {24{slot_en[w]}}};
        end
      endcase
      wmask = wmask & plane_mask;
      // rop bit index is {src, dst}; masked-off bits keep the stored value
      merged[32*w +: 32] = (((~src & ~d & {32{rop[0]}})
                           | (~src &  d & {32{rop[1]}})
                           | ( src & ~d & {32{rop[2]}})
                           | ( src &  d & {32{rop[3]}})) & wmask)
                           | (d & ~wmask);
    end
  end

endmodule : beat_merge

// *** test/mem_model.sv ***
// partner model: frame buffer memory answering the span engine port
// assumes one request held until mem_ack, all on core_clk
`timescale 1ns/1ps
module mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  dly,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [20:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic             mem_ack,
  output logic      [63:0] mem_rdata
);
  logic [63:0] mem [64];
  logic [3:0]  cnt_r;
  int          rd_cnt;
  int          wr_cnt;

  // answer after dly waiting cycles; read data only true beside ack
  always_ff @(posedge core_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata; // stale data must not look valid
    if (!rst_n) begin
      cnt_r     <= 4'h0;
      rd_cnt    <= 0;
      wr_cnt    <= 0;
      mem_rdata <= 64'h5a5a_5a5a_5a5a_5a5a;
      for (int i = 0; i < 64; i++)
        mem[i] <= 64'(i) * 64'h0101_0101_0101_0101 ^ 64'h0f1e_2d3c_4b5a_6978;
    end else if (mem_ack) begin
      cnt_r <= 4'h0;
    end else if (mem_req && cnt_r >= dly) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr[5:0]] <= mem_wdata;
        wr_cnt             <= wr_cnt + 1;
      end else begin
        mem_rdata <= mem[mem_addr[5:0]];
        rd_cnt    <= rd_cnt + 1;
      end
    end else if (mem_req) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : mem_model

// *** test/stipple_span_writer_tb.sv ***
// self-checking bench for the stipple span writer
// assumes mem_model as frame buffer memory, core_clk at 125 MHz
`timescale 1ns/1ps
module stipple_span_writer_tb
  import span_pkg::*;
;
  typedef struct {
    logic        transp;
    dst_fmt_t    fmt;
    logic [1:0]  dsel;
    logic [3:0]  rop;
    logic [31:0] pm;
    logic [31:0] pxm;
    logic [31:0] fg;
    logic [31:0] bg;
    logic [23:0] addr;
    logic [31:0] stip;
  } row_t;
  logic        core_clk;
  logic        rst_n;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        fb_wr;
  logic [23:0] fb_addr;
  logic [31:0] fb_data;
  logic        fb_busy;
  logic        mem_req;
  logic        mem_we;
  logic [20:0] mem_addr;
  logic [63:0] mem_wdata;
  logic        mem_ack;
  logic [63:0] mem_rdata;
  logic [3:0]  dly;
  logic [63:0] shadow [64];
  logic [31:0] rst_v [8];
  logic [31:0] d;
  row_t        rows [9];
  int          num_errors;
  int          checks_done;
  int          exp_beats;

  stipple_span_writer i_stipple_span_writer (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fb_wr(fb_wr), .fb_addr(fb_addr),
    .fb_data(fb_data), .fb_busy(fb_busy), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  mem_model i_mem_model (
    .core_clk(core_clk), .rst_n(rst_n), .dly(dly), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_write(input logic [4:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [4:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
    #1 chk(64'(reg_rdata), 64'h0);
  endtask : reg_read

  task automatic fb_pulse(input logic [23:0] a, input logic [31:0] s);
    @(posedge core_clk);
    fb_wr   <= 1'b1;
    fb_addr <= a; // aligned by the caller
    fb_data <= s; // edge masks already merged
    @(posedge core_clk);
    fb_wr <= 1'b0;
  endtask : fb_pulse

  // reference drawing into the shadow copy, one pixel at a time
  task automatic expect_span(input row_t r);
    logic [31:0] en, fm, c, dw, res, m;
    int a, w, q, b, first, last;
    a = int'(r.addr);
    en = r.transp ? r.stip : r.pxm;
    first = 99;
    last = -1;
    for (int k = 0; k < 32; k++) begin
      if (en[k]) begin
        w = (r.fmt == DST_PACKED8) ? (a + k) >> 2 : (a >> 2) + k;
        case (r.fmt)
          DST_PACKED8:   fm = 32'hff << (8 * ((a + k) % 4));
          DST_UNPACKED8: fm = 32'hff << (8 * r.dsel);
          DST_12BPP:     fm = r.dsel[0] ? 32'h00fff000 : 32'h00000fff;
          default:       fm = 32'h00ffffff;
        endcase
        c = (r.transp || r.stip[k]) ? r.fg : r.bg;
        // unpacked 8-bpp always draws the colour's low byte
        if (r.fmt == DST_UNPACKED8)
          c = {4{c[7:0]}};
        q = (w >> 1) % 64;
        dw = shadow[q][32*(w%2) +: 32];
        for (int i = 0; i < 32; i++)
          res[i] = r.rop[{c[i], dw[i]}];
        m = fm & r.pm;
        shadow[q][32*(w%2) +: 32] = (dw & ~m) | (res & m);
        b = (w >> 1) - (a >> 3);
        if (first > b) first = b;
        last = b;
      end
    end
    exp_beats = (last < 0) ? 0 : last - first + 1;
  endtask : expect_span

  // program one span, draw it, compare counts and the whole memory
  task automatic run_row(input row_t r, input logic ovr);
    int r0, w0;
    reg_write(PIXEL_MASK_OFS, r.pxm);
    reg_write(PLANE_MASK_OFS, r.pm);
    reg_write(ROP_OFS, {20'h0, r.dsel, r.fmt, 4'h0, r.rop});
    reg_write(FG_OFS, r.fg);
    reg_write(BG_OFS, r.bg);
    reg_write(MODE_OFS, {31'h0, r.transp});
    r0 = i_mem_model.rd_cnt;
    w0 = i_mem_model.wr_cnt;
    expect_span(r);
    fb_pulse(r.addr, r.stip);
    #1 chk(64'(fb_busy), 64'(exp_beats != 0));
    if (ovr) begin
      fb_pulse(r.addr + 24'h8, ~r.stip);
      reg_read(STATUS_OFS, d);
      chk(64'(d), 64'h3);
    end
    for (int i = 0; i < 500 && fb_busy === 1'b1; i++)
      @(posedge core_clk) #1;
    chk(64'(fb_busy), 64'h0);
    chk(64'(i_mem_model.wr_cnt - w0), 64'(exp_beats));
    chk(64'(i_mem_model.rd_cnt - r0), 64'(exp_beats));
    for (int i = 0; i < 64; i++)
      chk(i_mem_model.mem[i], shadow[i]);
    if (ovr) begin
      reg_read(STATUS_OFS, d);
      chk(64'(d), 64'h2);
      reg_write(STATUS_OFS, 32'h2);
      reg_read(STATUS_OFS, d);
      chk(64'(d), 64'h0);
    end
  endtask : run_row

  // main sequence: reset, registers, table of spans, overrun
  initial begin
    rst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fb_wr = 1'b0;
    fb_addr = 24'h0;
    fb_data = 32'h0;
    dly = 4'h0;
    num_errors = 0;
    checks_done = 0;
    rst_v = '{PIXEL_MASK_RST, PLANE_MASK_RST, ROP_RST, COLOUR_RST,
              COLOUR_RST, MODE_RST, 32'h0, 32'h0};
    rows[0] = '{1'b0, DST_PACKED8, 2'h0, 4'hc, 32'hffffffff, 32'hffffffff,
                32'h11223344, 32'ha5b6c7d8, 24'h000004, 32'h0f0f5aa5};
    rows[1] = '{1'b1, DST_PACKED8, 2'h0, 4'h6, 32'hffffffff, 32'h0,
                32'h0f0f0f0f, 32'h77777777, 24'h000040, 32'h00ff0180};
    rows[2] = '{1'b0, DST_UNPACKED8, 2'h2, 4'hc, 32'hffffffff, 32'h0ffffff0,
                32'h5a4b3c2d, 32'h1e2f3a4c, 24'h000080, 32'h12345678};
    rows[3] = '{1'b0, DST_12BPP, 2'h1, 4'hc, 32'hffffffff, 32'hffffffff,
                32'h00abcabc, 32'h00123123, 24'h000108, 32'h80000001};
    rows[4] = '{1'b1, DST_24BPP, 2'h0, 4'h3, 32'h00ffffff, 32'hffffffff,
                32'h00ffeedd, 32'h0, 24'h000188, 32'hf0f0f0f0};
    rows[5] = '{1'b0, DST_PACKED8, 2'h0, 4'h7, 32'h0f0f0f0f, 32'h7ffffffe,
                32'h96969696, 32'h69696969, 24'h0001e0, 32'ha5a5a5a5};
    rows[6] = '{1'b0, DST_24BPP, 2'h0, 4'hc, 32'hffffffff, 32'h0,
                32'h1, 32'h2, 24'h000010, 32'hffffffff};
    // plane mask zero: clear rop must leave memory untouched
    rows[7] = '{1'b0, DST_12BPP, 2'h0, 4'h0, 32'h0, 32'h00ffff00,
                32'h1, 32'h2, 24'h000100, 32'h0f0f0f0f};
    // transparent with clear stipple ignores a full pixel mask
    rows[8] = '{1'b1, DST_PACKED8, 2'h0, 4'hc, 32'hffffffff, 32'hffffffff,
                32'h3, 32'h4, 24'h000020, 32'h0};
    for (int i = 0; i < 64; i++)
      shadow[i] = 64'(i) * 64'h0101_0101_0101_0101 ^ 64'h0f1e_2d3c_4b5a_6978;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk({fb_busy, mem_req, reg_rdata}, 64'h0);
    // unmapped write must not land anywhere
    reg_write(5'h1c, 32'hdeadbeef);
    for (int i = 0; i < 8; i++) begin
      reg_read(5'(4 * i), d);
      chk(64'(d), 64'(rst_v[i]));
    end
    reg_write(ROP_OFS, 32'hffffffff);
    reg_read(ROP_OFS, d);
    chk(64'(d), 64'h0f0f);
    reg_write(MODE_OFS, 32'hffffffff);
    reg_read(MODE_OFS, d);
    chk(64'(d), 64'h1);
    // slow and prompt memory alternate across rows
    foreach (rows[i]) begin
      dly <= 4'(i % 4);
      run_row(rows[i], 1'b0);
    end
    dly <= 4'h3;
    run_row(rows[0], 1'b1);
    close_out();
  end
endmodule : stipple_span_writer_tb
